// [udc_cmd_regs.sv]
// Purpose: command-addressed dma config, interrupt and endpoint status registers
// Assumes: host strobes a command byte, then data reads or writes
// Notes: read data is registered and presented one cycle after the strobe
module udc_cmd_regs #(
    parameter int ENDPOINTS = 6
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // parallel command port
    input wire logic cmd_wr_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    // usb engine events
    input wire logic trans_valid_i,
    input wire logic [2:0] trans_index_i,
    input wire logic [7:0] trans_status_i,
    input wire logic sof_i,
    input wire logic bus_reset_i,
    input wire logic resume_i,
    input wire logic [ENDPOINTS-1:0] buffer_full_i,
    input wire logic [ENDPOINTS-1:0] stalled_i,
    // mode settings held elsewhere
    input wire logic irq_on_nak_err_i,
    input wire logic sof_only_irq_i,
    // dma
    input wire logic transfer_end_in_n_i,
    input wire logic dma_done_i,
    output logic dma_enable_o,
    output logic dma_direction_o,
    output logic [4:0] dma_burst_len_o,
    output logic dma_restart_o,
    // interrupt pin and suspend state
    output logic irq_o,
    output logic suspended_o
);
    if (ENDPOINTS != udc_pkg::NUM_ENDPOINTS) begin
        $error("endpoint count must be six");
    end

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_CFG = 5'h02,
        ST_IRQ1 = 5'h04,
        ST_IRQ2 = 5'h08,
        ST_SEL = 5'h10
    } udc_state_type;

    udc_ev_if ev();

    udc_state_type state, next_state;
    logic [7:0] dma_configuration, next_dma_configuration;
    logic [7:6] irq_low_misc, next_irq_low_misc;
    logic dma_end_flag, next_dma_end_flag;
    logic [7:0] rdata, next_rdata;
    logic [1:0] sof_miss, next_sof_miss;
    logic suspended, next_suspended;
    logic frame_tick;
    logic [7:0] irq_low;
    logic [ENDPOINTS-1:0] ep_enabled;

    function automatic logic [4:0] burst_len(input logic [1:0] code);
        unique case (code)
            udc_pkg::BURST_SINGLE: burst_len = udc_pkg::LEN_SINGLE;
            udc_pkg::BURST_4: burst_len = udc_pkg::LEN_4;
            udc_pkg::BURST_8: burst_len = udc_pkg::LEN_8;
            udc_pkg::BURST_16: burst_len = udc_pkg::LEN_16;
        endcase
    endfunction

    function automatic logic in_range(input logic [7:0] cmd, input logic [7:0] base);
        in_range = (cmd >= base) && (cmd < base + 8'(ENDPOINTS));
    endfunction

    udc_trans_track #(.ENDPOINTS(ENDPOINTS)) u_track (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .irq_on_nak_err_i(irq_on_nak_err_i),
        .ev(ev.sink)
    );

    // limitation: no frame timer in this block, so suspend entry never fires
    assign frame_tick = 1'b0;
    assign ev.valid = trans_valid_i;
    assign ev.endpoint_index = trans_index_i;
    assign ev.status = trans_status_i;
    assign ev.clear_index = data_i[2:0];
    assign ev.flag_clear = cmd_wr_i && in_range(data_i, udc_pkg::CMD_TRANS_BASE);

    always_comb begin
        ep_enabled = '1;
        ep_enabled[4] = dma_configuration[udc_pkg::CFG_EP4_IRQ_EN];
        ep_enabled[5] = dma_configuration[udc_pkg::CFG_EP5_IRQ_EN];
        irq_low = {irq_low_misc, ev.flags & ep_enabled};
    end

    always_comb begin
        next_state = state;
        next_dma_configuration = dma_configuration;
        next_irq_low_misc = irq_low_misc;
        next_dma_end_flag = dma_end_flag;
        next_rdata = rdata;
        next_sof_miss = sof_miss;
        next_suspended = suspended;
        if (cmd_wr_i) begin
            next_state = ST_IDLE;
            if (data_i == udc_pkg::CMD_DMA_CONFIG) begin
                next_state = ST_CFG;
                next_rdata = dma_configuration;
            end else if (data_i == udc_pkg::CMD_READ_IRQ) begin
                next_state = ST_IRQ1;
                next_rdata = irq_low;
            end else if (in_range(data_i, udc_pkg::CMD_SELECT_BASE)) begin
                next_state = ST_SEL;
                next_rdata = 8'h00;
                next_rdata[udc_pkg::SEL_FULL] = buffer_full_i[data_i[2:0]];
                next_rdata[udc_pkg::SEL_STALL] = stalled_i[data_i[2:0]];
            end else if (in_range(data_i, udc_pkg::CMD_TRANS_BASE)) begin
                next_rdata = ev.read_status;
            end
        end else if (data_wr_i) begin
            unique case (state)
                ST_CFG: next_dma_configuration = data_i;
                ST_IDLE, ST_IRQ1, ST_IRQ2, ST_SEL: next_state = state;
            endcase
        end else if (data_rd_i) begin
            unique case (state)
                ST_IRQ1: begin
                    next_irq_low_misc = 2'b00;
                    next_rdata = {7'h00, dma_end_flag};
                    next_state = ST_IRQ2;
                end
                ST_IRQ2: begin
                    next_dma_end_flag = 1'b0;
                    next_state = ST_IDLE;
                end
                ST_CFG, ST_IDLE, ST_SEL: next_state = state;
            endcase
        end
        // hardware sets win over read clears
        if (bus_reset_i) next_irq_low_misc[udc_pkg::IRQ_BUS_RESET] = 1'b1;
        if (dma_done_i) next_dma_end_flag = 1'b1;
        if (!transfer_end_in_n_i) begin
            next_dma_configuration[udc_pkg::CFG_ENABLE] = 1'b0;
            next_dma_end_flag = 1'b1;
        end
        if (sof_i) begin
            next_sof_miss = 2'b00;
            if (suspended || resume_i) begin
                next_suspended = 1'b0;
                if (suspended) next_irq_low_misc[udc_pkg::IRQ_SUSPEND_CHANGE] = 1'b1;
            end
        end else if (frame_tick && !suspended) begin
            if (sof_miss == 2'(udc_pkg::SOF_MISS_SUSPEND - 1)) begin
                next_suspended = 1'b1;
                next_irq_low_misc[udc_pkg::IRQ_SUSPEND_CHANGE] = 1'b1;
            end else begin
                next_sof_miss = sof_miss + 2'h1;
            end
        end
        if (resume_i && suspended) begin
            next_suspended = 1'b0;
            next_irq_low_misc[udc_pkg::IRQ_SUSPEND_CHANGE] = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            dma_configuration <= udc_pkg::CFG_RESET;
            irq_low_misc <= 2'b00;
            dma_end_flag <= 1'b0;
            rdata <= 8'h00;
            sof_miss <= 2'h0;
            suspended <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            dma_configuration <= next_dma_configuration;
            irq_low_misc <= next_irq_low_misc;
            dma_end_flag <= next_dma_end_flag;
            rdata <= next_rdata;
            sof_miss <= next_sof_miss;
            suspended <= next_suspended;
        end
    end

    assign data_o = rdata;
    assign dma_enable_o = dma_configuration[udc_pkg::CFG_ENABLE];
    assign dma_direction_o = dma_configuration[udc_pkg::CFG_DIRECTION];
    assign dma_burst_len_o = burst_len(dma_configuration[udc_pkg::CFG_BURST_LO +: 2]);
    // restart only when auto restart is set and dma still enabled
    assign dma_restart_o = dma_done_i && dma_configuration[udc_pkg::CFG_AUTO_RESTART]
        && dma_configuration[udc_pkg::CFG_ENABLE];
    assign suspended_o = suspended;
    // level output; sof-only mode overrides the pin mode bit
    assign irq_o = sof_only_irq_i ? sof_i
        : ((|irq_low) || dma_end_flag || (dma_configuration[udc_pkg::CFG_PIN_MODE] && sof_i));
endmodule

// [udc_pkg.sv]
// Purpose: constants for the usb device command register block
// Assumes: 8-bit parallel command/data port, one core clock
// Notes: command codes and bit positions of the config and status bytes
package udc_pkg;
    localparam logic [7:0] CMD_DMA_CONFIG = 8'hfb;
    localparam logic [7:0] CMD_READ_IRQ = 8'hf4;
    localparam logic [7:0] CMD_SELECT_BASE = 8'h00;
    localparam logic [7:0] CMD_TRANS_BASE = 8'h40;
    localparam int NUM_ENDPOINTS = 6;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam int CFG_BURST_LO = 0;
    localparam int CFG_ENABLE = 2;
    localparam int CFG_DIRECTION = 3;
    localparam int CFG_AUTO_RESTART = 4;
    localparam int CFG_PIN_MODE = 5;
    localparam int CFG_EP4_IRQ_EN = 6;
    localparam int CFG_EP5_IRQ_EN = 7;
    localparam int IRQ_BUS_RESET = 6;
    localparam int IRQ_SUSPEND_CHANGE = 7;
    localparam int IRQ_DMA_END = 0;
    localparam int SEL_FULL = 0;
    localparam int SEL_STALL = 1;
    localparam int TR_SUCCESS = 0;
    localparam int TR_ERR_LO = 1;
    localparam int TR_SETUP = 5;
    localparam int TR_TOGGLE = 6;
    localparam int TR_OVERWRITE = 7;
    localparam int SOF_MISS_SUSPEND = 3;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_PID_ENCODING = 4'h1;
    localparam logic [3:0] ERR_PID_UNKNOWN = 4'h2;
    localparam logic [3:0] ERR_UNEXPECTED = 4'h3;
    localparam logic [3:0] ERR_TOKEN_CRC = 4'h4;
    localparam logic [3:0] ERR_DATA_CRC = 4'h5;
    localparam logic [3:0] ERR_TIMEOUT = 4'h6;
    localparam logic [3:0] ERR_UNEXPECTED_EOP = 4'h8;
    localparam logic [3:0] ERR_NAKED = 4'h9;
    localparam logic [3:0] ERR_STALL_SENT = 4'ha;
    localparam logic [3:0] ERR_OVERFLOW = 4'hb;
    localparam logic [3:0] ERR_BIT_STUFF = 4'hd;
    localparam logic [3:0] ERR_WRONG_DATA_PID = 4'hf;
    localparam logic [1:0] BURST_SINGLE = 2'h0;
    localparam logic [1:0] BURST_4 = 2'h1;
    localparam logic [1:0] BURST_8 = 2'h2;
    localparam logic [1:0] BURST_16 = 2'h3;
    localparam logic [4:0] LEN_SINGLE = 5'h01;
    localparam logic [4:0] LEN_4 = 5'h04;
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_16 = 5'h10;
endpackage

// [udc_ev_if.sv]
// Purpose: transaction event carrier between the tracker and the top
// Assumes: one event per cycle at most
// Notes: the top drives the event fields, the tracker consumes them and drives flags and read_status back
interface udc_ev_if;
    logic valid;
    logic [2:0] endpoint_index;
    logic [7:0] status;
    logic flag_clear;
    logic [2:0] clear_index;
    logic [5:0] flags;
    logic [7:0] read_status;
    modport source (output valid, endpoint_index, status, flag_clear, clear_index, input flags, read_status);
    modport sink (input valid, endpoint_index, status, flag_clear, clear_index, output flags, read_status);
endinterface

// [udc_trans_track.sv]
// Purpose: per-endpoint last-transaction status and endpoint flags
// Assumes: status bytes arrive already assembled by the serial engine
// Notes: a new event on the cleared endpoint beats the clear
module udc_trans_track #(
    parameter int ENDPOINTS = 6
) (
    // clock and control
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic irq_on_nak_err_i,
    // event carrier
    udc_ev_if.sink ev
);
    if (ENDPOINTS != udc_pkg::NUM_ENDPOINTS) begin
        $error("endpoint count must be six");
    end
    logic [7:0] result [ENDPOINTS];
    logic [7:0] next_result [ENDPOINTS];
    logic [ENDPOINTS-1:0] unread;
    logic [ENDPOINTS-1:0] next_unread;
    logic [ENDPOINTS-1:0] flags;
    logic [ENDPOINTS-1:0] next_flags;

    function automatic logic raises(input logic [7:0] st, input logic mode);
        raises = st[udc_pkg::TR_SUCCESS] || mode;
    endfunction

    always_comb begin
        next_result = result;
        next_unread = unread;
        next_flags = flags;
        if (ev.flag_clear) begin
            next_unread[ev.clear_index] = 1'b0;
            next_flags[ev.clear_index] = 1'b0;
        end
        if (ev.valid) begin
            next_result[ev.endpoint_index] = ev.status;
            // a status read in this same cycle counts as read
            next_result[ev.endpoint_index][udc_pkg::TR_OVERWRITE] = next_unread[ev.endpoint_index];
            next_unread[ev.endpoint_index] = 1'b1;
            // nak and errored results only flag when the mode allows
            if (raises(ev.status, irq_on_nak_err_i)) begin
                next_flags[ev.endpoint_index] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < ENDPOINTS; i++) begin
                result[i] <= 8'h00;
            end
            unread <= '0;
            flags <= '0;
        end else if (ce_i) begin
            result <= next_result;
            unread <= next_unread;
            flags <= next_flags;
        end
    end

    assign ev.flags = flags;
    assign ev.read_status = result[ev.clear_index];
endmodule

// [udc_cmd_regs_properties.sv]
// Purpose: port checks for udc_cmd_regs
// Assumes: one clock, sync reset high
// Notes: bound to every instance
module udc_cmd_regs_chk #(
    parameter int ENDPOINTS = 6
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // watched ports
    input wire logic cmd_wr_i,
    input wire logic data_wr_i,
    input wire logic data_rd_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic trans_valid_i,
    input wire logic [2:0] trans_index_i,
    input wire logic [7:0] trans_status_i,
    input wire logic sof_i,
    input wire logic bus_reset_i,
    input wire logic [ENDPOINTS-1:0] buffer_full_i,
    input wire logic [ENDPOINTS-1:0] stalled_i,
    input wire logic sof_only_irq_i,
    input wire logic transfer_end_in_n_i,
    input wire logic dma_done_i,
    input wire logic dma_enable_o,
    input wire logic [4:0] dma_burst_len_o,
    input wire logic dma_restart_o,
    input wire logic irq_o,
    input wire logic suspended_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // sof excluded so that irq can only stem from flags
    logic quiet;
    assign quiet = ce_i && !sof_i && !sof_only_irq_i;
    a_restart_gate: assert property (dma_restart_o |-> dma_done_i && dma_enable_o)
        else $error("restart without done and enable");
    a_eot_disable: assert property (ce_i && !transfer_end_in_n_i |=> !dma_enable_o)
        else $error("enable kept after end of transfer");
    a_burst_decode: assert property (dma_burst_len_o inside {5'h01, 5'h04, 5'h08, 5'h10})
        else $error("burst length not decoded");
    a_reset_zero: assert property ($fell(rst_i) |-> !dma_enable_o && !suspended_o && data_o == 8'h00)
        else $error("state not zero after reset");
    a_sof_only: assert property (sof_only_irq_i |-> irq_o == sof_i)
        else $error("irq not following sof");
    a_irq_hold: assert property (irq_o && quiet && !cmd_wr_i && !data_wr_i && !data_rd_i
        |=> irq_o || sof_only_irq_i)
        else $error("irq dropped without a clear");
    a_flag_raise: assert property (quiet && trans_valid_i && trans_status_i[0] && trans_index_i < 3'h4
        |=> irq_o || sof_only_irq_i)
        else $error("endpoint flag not raised");
    a_bus_reset_flag: assert property (quiet && bus_reset_i |=> irq_o || sof_only_irq_i)
        else $error("bus reset flag not raised");
    a_select_answer: assert property (ce_i && cmd_wr_i && data_i < 8'h06 |=>
        data_o[1:0] == {$past(stalled_i[data_i[2:0]]), $past(buffer_full_i[data_i[2:0]])})
        else $error("select status wrong");
    a_ce_freeze: assert property (!ce_i |=> $stable(data_o) && $stable(dma_enable_o) && $stable(suspended_o))
        else $error("state moved while clock enable low");
endmodule

bind udc_cmd_regs udc_cmd_regs_chk #(.ENDPOINTS(ENDPOINTS)) chk (.clock_i, .rst_i, .ce_i, .cmd_wr_i,
    .data_wr_i, .data_rd_i, .data_i, .data_o, .trans_valid_i, .trans_index_i, .trans_status_i, .sof_i,
    .bus_reset_i, .buffer_full_i, .stalled_i, .sof_only_irq_i, .transfer_end_in_n_i, .dma_done_i,
    .dma_enable_o, .dma_burst_len_o, .dma_restart_o, .irq_o, .suspended_o);

// [udc_host_model.sv]
// Purpose: microcontroller side of the command port
// Assumes: one strobe per transfer, one cycle long
// Notes: kind 0 command, 1 data write, 2 data read
module udc_host_model (
    // clock
    input wire logic clock_i,
    // parallel port
    output logic cmd_wr_o,
    output logic data_wr_o,
    output logic data_rd_o,
    output logic [7:0] data_o,
    input wire logic [7:0] data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cmd_wr_o, data_wr_o, data_rd_o} = 3'h0;
        data_o = 8'h00;
    end
    // released bus shows the inverse, never a stale byte
    task automatic xfer(input logic [1:0] kind, input logic [7:0] value);
        @(posedge clock_i);
        {cmd_wr_o, data_wr_o, data_rd_o} <= 3'h4 >> kind;
        data_o <= value;
        @(posedge clock_i);
        {cmd_wr_o, data_wr_o, data_rd_o} <= 3'h0;
        data_o <= ~value;
    endtask
    task automatic get(output logic [7:0] value);
        @(posedge clock_i);
        #1;
        value = data_i;
    endtask
endmodule

// [usb_dev_dma_irq_ep_status_tb_top.sv]
// Purpose: self-checking bench for udc_cmd_regs
// Assumes: host model drives the command port
// Notes: rows cover burst sizes and every error code
module usb_dev_dma_irq_ep_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] cfg;
        logic [4:0] len;
        logic [3:0] code;
    } udc_row_type;
    localparam logic [5:0] full_map = 6'h2a;
    localparam logic [5:0] stall_map = 6'h0c;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic tv = 1'b0, sof = 1'b0, brst = 1'b0, done = 1'b0, nak = 1'b1, sofo = 1'b0, transfer_end_in_n = 1'b1;
    logic ce = 1'b1, wake = 1'b0;
    logic [2:0] ti = 3'h0;
    logic [7:0] ts = 8'h00;
    logic cmd_wr, data_wr, data_rd, dma_en, dma_dir, restart, irq, susp;
    logic [7:0] bus_d, data_o, v, st;
    logic [4:0] len;
    logic [2:0] ep;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    udc_row_type rows [13] = '{'{8'hc0, 5'h01, 4'h0}, '{8'hc5, 5'h04, 4'h1}, '{8'hca, 5'h08, 4'h2},
        '{8'hcf, 5'h10, 4'h3}, '{8'hd0, 5'h01, 4'h4}, '{8'hd5, 5'h04, 4'h5}, '{8'hda, 5'h08, 4'h6},
        '{8'hdf, 5'h10, 4'h8}, '{8'he1, 5'h04, 4'h9}, '{8'he6, 5'h08, 4'ha}, '{8'heb, 5'h10, 4'hb},
        '{8'hec, 5'h01, 4'hd}, '{8'hf3, 5'h10, 4'hf}};
    udc_cmd_regs #(.ENDPOINTS(6)) uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce), .cmd_wr_i(cmd_wr),
        .data_wr_i(data_wr), .data_rd_i(data_rd), .data_i(bus_d), .data_o(data_o), .trans_valid_i(tv),
        .trans_index_i(ti), .trans_status_i(ts), .sof_i(sof), .bus_reset_i(brst), .resume_i(wake),
        .buffer_full_i(full_map), .stalled_i(stall_map), .irq_on_nak_err_i(nak), .sof_only_irq_i(sofo),
        .transfer_end_in_n_i(transfer_end_in_n), .dma_done_i(done), .dma_enable_o(dma_en), .dma_direction_o(dma_dir),
        .dma_burst_len_o(len), .dma_restart_o(restart), .irq_o(irq), .suspended_o(susp));
    udc_host_model host (.clock_i(clock_i), .cmd_wr_o(cmd_wr), .data_wr_o(data_wr), .data_rd_o(data_rd),
        .data_o(bus_d), .data_i(data_o));
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] want, input logic [7:0] mask);
        host.xfer(2'd0, c);
        host.get(v);
        check(v & mask, want);
    endtask
    task automatic pop(input logic [7:0] want);
        host.xfer(2'd2, 8'h00);
        host.get(v);
        check(v & 8'h01, want);
    endtask
    task automatic set_cfg(input logic [7:0] c);
        host.xfer(2'd0, 8'hfb);
        host.xfer(2'd1, c);
        #1;
    endtask
    task automatic trans(input logic [2:0] e, input logic [7:0] s);
        @(posedge clock_i);
        tv <= 1'b1;
        ti <= e;
        ts <= s;
        @(posedge clock_i);
        tv <= 1'b0;
        #1;
    endtask
    task automatic sof_pulse(input logic want);
        @(posedge clock_i);
        sof <= 1'b1;
        #1;
        check(8'(irq), 8'(want));
        @(posedge clock_i);
        sof <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(8'hfb, 8'h00, 8'hff);
        rd(8'hf4, 8'h00, 8'hff);
        rd(8'h45, 8'h00, 8'hff);
        check(8'({dma_en, dma_dir, restart, irq, susp}), 8'h00);
        foreach (rows[i]) begin
            ep = 3'(i % 6);
            st = {1'b0, i[0], i[1], rows[i].code, rows[i].code == 4'h0};
            set_cfg(rows[i].cfg);
            check({dma_en, dma_dir, 1'b0, len}, {rows[i].cfg[2], rows[i].cfg[3], 1'b0, rows[i].len});
            rd(8'hfb, rows[i].cfg, 8'hff);
            trans(ep, st);
            check(8'(irq), 8'h01);
            rd(8'hf4, 8'h01 << ep, 8'h3f);
            rd(8'h40 + 8'(ep), st, 8'hff);
            check(8'(irq), 8'h00);
        end
        trans(3'h2, 8'h01);
        trans(3'h2, 8'h12);
        rd(8'h42, 8'h92, 8'hff);
        set_cfg(8'h00);
        trans(3'h4, 8'h01);
        check(8'(irq), 8'h00);
        rd(8'h44, 8'h01, 8'hff);
        @(posedge clock_i);
        nak <= 1'b0;
        trans(3'h0, 8'h12);
        check(8'(irq), 8'h00);
        rd(8'h40, 8'h12, 8'hff);
        for (int k = 0; k < 6; k++) begin
            rd(8'(k), {6'h00, stall_map[k], full_map[k]}, 8'h03);
        end
        set_cfg(8'h14);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock_i);
            done <= 1'b1;
            #1;
            check(8'(restart), 8'(k == 0));
            @(posedge clock_i);
            done <= 1'b0;
            set_cfg(8'h04);
        end
        @(posedge clock_i);
        transfer_end_in_n <= 1'b0;
        @(posedge clock_i);
        transfer_end_in_n <= 1'b1;
        #1;
        check(8'({dma_en, irq}), 8'h01);
        rd(8'hf4, 8'h00, 8'hff);
        pop(8'h01);
        host.xfer(2'd2, 8'h00);
        #1;
        check(8'(irq), 8'h00);
        @(posedge clock_i);
        brst <= 1'b1;
        @(posedge clock_i);
        brst <= 1'b0;
        rd(8'hf4, 8'h40, 8'h40);
        pop(8'h00);
        rd(8'hf4, 8'h00, 8'h40);
        set_cfg(8'h20);
        sof_pulse(1'b1);
        set_cfg(8'h00);
        sof_pulse(1'b0);
        @(posedge clock_i);
        sofo <= 1'b1;
        brst <= 1'b1;
        @(posedge clock_i);
        brst <= 1'b0;
        #1;
        check(8'(irq), 8'h00);
        sof_pulse(1'b1);
        @(posedge clock_i);
        sofo <= 1'b0;
        #1;
        check(8'(irq), 8'h01);
        host.xfer(2'd0, 8'hf4);
        host.xfer(2'd2, 8'h00);
        #1;
        check(8'(irq), 8'h00);
        // strobes while the clock enable is low must leave the config alone
        @(posedge clock_i);
        ce <= 1'b0;
        set_cfg(8'hff);
        @(posedge clock_i);
        ce <= 1'b1;
        rd(8'hfb, 8'h00, 8'hff);
        // resume while not suspended is no state change
        @(posedge clock_i);
        wake <= 1'b1;
        @(posedge clock_i);
        wake <= 1'b0;
        rd(8'hf4, 8'h00, 8'h80);
        check(8'(susp), 8'h00);
        finish_test();
    end
endmodule
